// ---- hw/fcs_ctrl.sv ----
// Purpose: flash command, status, protection and configuration control on apb
// Assumes: flash array engine, stop request and bdm port run on pclk
// Notes: one buffer entry; only burst programs overlap a running command
// What this block does
// - config bits 7:5 read/write, 4:0 zero
// - key bit clear: flash writes start commands
// - key bit set: key writes, array reads invalid
// - protection byte reset to 01, loaded from nonvolatile copy on first clock after reset
// - protection readable; only debug writes change it
// - select field sets end of unprotected flash
// - disable bit one protects nothing
// - status bits 3, 1, 0 read zero
// - writing one to buffer-empty launches, clears it
// - only burst programs are buffered
// - complete flag: buffer empty and idle
// - protected target: ignore, set violation, w1c
// - broken sequence, no divider, stop during a command: access error
// - access error cleared only by writing one
// - blank flag set by successful blank check
// - codes 05, 20, 25 accepted
// - codes 40 and 41 accepted
// - other codes raise access error
// - divider write sets divisor-loaded, enables program
// - successful blank check unsecures the part
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_ctrl (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	// cpu writes into the flash address space
	input wire logic flash_wr,
	input wire logic [15:0] flash_wr_addr,
	input wire logic [7:0] flash_wr_data,
	output logic read_invalid_q,
	// backdoor key comparison writes
	output logic key_wr_q,
	output logic [2:0] key_idx_q,
	output logic [7:0] key_data_q,
	// nonvolatile copies and debug port
	input wire logic [7:0] nonvolatile_protection_byte,
	input wire logic bdm_prot_wr,
	input wire logic [7:0] bdm_prot_data,
	input wire logic stop_req,
	// array engine
	output logic array_start_q,
	output logic [7:0] array_cmd_q,
	output logic [15:0] array_addr_q,
	output logic [7:0] array_data_q,
	input wire logic array_done,
	input wire logic array_blank_ok,
	output logic [1:0] security_state_code_q
);
	// ****************************************
	// decode
	// ****************************************
	logic setup, done, mapped, prot_hit;
	logic [2:0] cfg_q, cfg_d;
	logic [7:0] prot_q, prot_d, cmd_q, cmd_d, div_q, div_d;
	logic prot_ld_q, prot_ld_d;
	logic cbef_q, cbef_d, ccf_q, ccf_d, pviol_q, pviol_d;
	logic accerr_q, accerr_d, blank_q, blank_d, divisor_loaded_q, divisor_loaded_d;
	logic busy_q, busy_d, hold_q, hold_d;
	logic [7:0] run_cmd_q, run_cmd_d, buf_cmd_q, buf_cmd_d, buf_data_q, buf_data_d;
	logic [15:0] buf_addr_q, buf_addr_d;
	logic [1:0] sec_d;
	fcs_pkg::fcs_seq_t seq_q, seq_d;
	logic [31:0] prdata_d;
	logic pslverr_d, key_wr_d, start_d;
	logic [2:0] key_idx_d;
	logic [7:0] key_data_d, a_cmd_d, a_data_d;
	logic [15:0] a_addr_d;
	logic wr_cfg, wr_prot, wr_stat, wr_cmd, wr_div, launch, launch_ok, key_hit, legal;

	function automatic logic is_legal(input logic [7:0] c);
		is_legal = (c == `FCS_CMD_BLANK) | (c == `FCS_CMD_BYTE) | (c == `FCS_CMD_BURST) |
			(c == `FCS_CMD_PAGE) | (c == `FCS_CMD_MASS);
	endfunction

	function automatic logic wr_to(input logic [7:0] ofs);
		wr_to = done & pwrite & (paddr == ofs);
	endfunction

	fcs_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.paddr(paddr),
		.pready_q(pready_q),
		.setup(setup),
		.done(done),
		.mapped(mapped)
	);

	fcs_prot_chk u_prot (
		.prot(prot_q),
		.cmd(cmd_q),
		.addr(buf_addr_q),
		.hit(prot_hit)
	);

	assign wr_cfg = wr_to(`FCS_OFS_CONFIG);
	assign wr_prot = wr_to(`FCS_OFS_PROT);
	assign wr_stat = wr_to(`FCS_OFS_STATUS);
	assign wr_cmd = wr_to(`FCS_OFS_CMD);
	assign wr_div = wr_to(`FCS_OFS_DIV);
	assign launch = wr_stat & pwdata[`FCS_BIT_CBEF];
	assign legal = is_legal(cmd_q);
	assign launch_ok = launch & (seq_q == fcs_pkg::FCS_SEQ_CMD) & legal & divisor_loaded_q &
		~prot_hit & cbef_q &
		(~busy_q | ((run_cmd_q == `FCS_CMD_BURST) & (cmd_q == `FCS_CMD_BURST)));
	assign key_hit = (flash_wr_addr >= `FCS_KEY_LO) & (flash_wr_addr <= `FCS_KEY_HI);

	// ****************************************
	// register and sequence next state
	// ****************************************
	always_comb
	begin
		cfg_d = cfg_q;
		prot_d = prot_q;
		prot_ld_d = 1'b1;
		cmd_d = cmd_q;
		div_d = div_q;
		divisor_loaded_d = divisor_loaded_q;
		cbef_d = cbef_q;
		pviol_d = pviol_q;
		accerr_d = accerr_q;
		blank_d = blank_q;
		busy_d = busy_q;
		hold_d = hold_q;
		run_cmd_d = run_cmd_q;
		buf_cmd_d = buf_cmd_q;
		buf_addr_d = buf_addr_q;
		buf_data_d = buf_data_q;
		sec_d = security_state_code_q;
		seq_d = seq_q;
		key_wr_d = 1'b0;
		key_idx_d = key_idx_q;
		key_data_d = key_data_q;
		start_d = 1'b0;
		a_cmd_d = array_cmd_q;
		a_addr_d = array_addr_q;
		a_data_d = array_data_q;
		if (wr_cfg)
			cfg_d = pwdata[7:5];
		// nonvolatile copy taken once after reset release
		if (!prot_ld_q)
			prot_d = nonvolatile_protection_byte;
		// debug writes only, apb writes dropped
		else if (bdm_prot_wr)
			prot_d = bdm_prot_data;
		if (wr_div)
		begin
			div_d = pwdata[7:0];
			divisor_loaded_d = 1'b1;
		end
		// write one clears, set wins below
		if (wr_stat && pwdata[`FCS_BIT_PVIOL])
			pviol_d = 1'b0;
		if (wr_stat && pwdata[`FCS_BIT_ACCERR])
			accerr_d = 1'b0;
		if (flash_wr)
		begin
			// key mode diverts the key window
			if (cfg_q[`FCS_BIT_KEY_WRITE_ENABLE - 5] && key_hit)
			begin
				key_wr_d = 1'b1;
				key_idx_d = flash_wr_addr[2:0];
				key_data_d = flash_wr_data;
			end
			else if (seq_q == fcs_pkg::FCS_SEQ_IDLE && cbef_q)
			begin
				buf_addr_d = flash_wr_addr;
				buf_data_d = flash_wr_data;
				seq_d = fcs_pkg::FCS_SEQ_DATA;
			end
			else
			begin
				accerr_d = 1'b1;
				seq_d = fcs_pkg::FCS_SEQ_IDLE;
			end
		end
		if (wr_cmd)
		begin
			cmd_d = pwdata[7:0];
			if (seq_q == fcs_pkg::FCS_SEQ_DATA)
				seq_d = fcs_pkg::FCS_SEQ_CMD;
			else
			begin
				accerr_d = 1'b1;
				seq_d = fcs_pkg::FCS_SEQ_IDLE;
			end
		end
		if (launch)
		begin
			seq_d = fcs_pkg::FCS_SEQ_IDLE;
			if (launch_ok)
			begin
				cbef_d = 1'b0;
				// a new valid command clears blank
				blank_d = 1'b0;
				buf_cmd_d = cmd_q;
			end
			else if (seq_q == fcs_pkg::FCS_SEQ_CMD && legal && divisor_loaded_q && prot_hit)
				pviol_d = 1'b1;
			else
				accerr_d = 1'b1;
		end
		// buffer moves to the array when the engine is free
		if (!cbef_q && !busy_q)
		begin
			start_d = 1'b1;
			busy_d = 1'b1;
			run_cmd_d = buf_cmd_q;
			a_cmd_d = buf_cmd_q;
			a_addr_d = buf_addr_q;
			a_data_d = buf_data_q;
			// burst frees the buffer at once
			hold_d = buf_cmd_q != `FCS_CMD_BURST;
			cbef_d = buf_cmd_q == `FCS_CMD_BURST;
		end
		if (busy_q && array_done)
		begin
			busy_d = 1'b0;
			hold_d = 1'b0;
			if (hold_q)
				cbef_d = 1'b1;
			if (run_cmd_q == `FCS_CMD_BLANK && array_blank_ok)
			begin
				blank_d = 1'b1;
				sec_d = `FCS_SEC_UNSEC;
			end
		end
		// stop during a command aborts it
		if (stop_req && (busy_q || !cbef_q))
		begin
			accerr_d = 1'b1;
			busy_d = 1'b0;
			hold_d = 1'b0;
			cbef_d = 1'b1;
			start_d = 1'b0;
		end
		ccf_d = cbef_d & ~busy_d;
	end

	// ****************************************
	// read data and error
	// ****************************************
	always_comb
	begin
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		if (setup)
		begin
			prdata_d = 32'h0000_0000;
			pslverr_d = ~mapped;
			case (paddr)
				`FCS_OFS_CONFIG: prdata_d[7:5] = cfg_q;
				`FCS_OFS_PROT: prdata_d[7:0] = prot_q;
				// bits 3, 1, 0 stay zero
				`FCS_OFS_STATUS:
				begin
					prdata_d[`FCS_BIT_CBEF] = cbef_q;
					prdata_d[`FCS_BIT_CCF] = ccf_q;
					prdata_d[`FCS_BIT_PVIOL] = pviol_q;
					prdata_d[`FCS_BIT_ACCERR] = accerr_q;
					prdata_d[`FCS_BIT_BLANK] = blank_q;
				end
				`FCS_OFS_CMD: prdata_d[7:0] = cmd_q;
				`FCS_OFS_DIV: prdata_d[7:0] = {divisor_loaded_q, div_q[6:0]};
				`FCS_OFS_SEC: prdata_d[1:0] = security_state_code_q;
				default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q <= 3'h0;
			prot_q <= `FCS_PROT_RST;
			prot_ld_q <= 1'b0;
			cmd_q <= 8'h00;
			div_q <= 8'h00;
			divisor_loaded_q <= 1'b0;
			cbef_q <= 1'b1;
			ccf_q <= 1'b1;
			pviol_q <= 1'b0;
			accerr_q <= 1'b0;
			blank_q <= 1'b0;
			busy_q <= 1'b0;
			hold_q <= 1'b0;
			run_cmd_q <= 8'h00;
			buf_cmd_q <= 8'h00;
			buf_addr_q <= 16'h0000;
			buf_data_q <= 8'h00;
			security_state_code_q <= `FCS_SEC_RST;
			seq_q <= fcs_pkg::FCS_SEQ_IDLE;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			read_invalid_q <= 1'b0;
			key_wr_q <= 1'b0;
			key_idx_q <= 3'h0;
			key_data_q <= 8'h00;
			array_start_q <= 1'b0;
			array_cmd_q <= 8'h00;
			array_addr_q <= 16'h0000;
			array_data_q <= 8'h00;
		end
		else
		begin
			cfg_q <= cfg_d;
			prot_q <= prot_d;
			prot_ld_q <= prot_ld_d;
			cmd_q <= cmd_d;
			div_q <= div_d;
			divisor_loaded_q <= divisor_loaded_d;
			cbef_q <= cbef_d;
			ccf_q <= ccf_d;
			pviol_q <= pviol_d;
			accerr_q <= accerr_d;
			blank_q <= blank_d;
			busy_q <= busy_d;
			hold_q <= hold_d;
			run_cmd_q <= run_cmd_d;
			buf_cmd_q <= buf_cmd_d;
			buf_addr_q <= buf_addr_d;
			buf_data_q <= buf_data_d;
			security_state_code_q <= sec_d;
			seq_q <= seq_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
			// array reads invalid in key mode
			read_invalid_q <= cfg_d[`FCS_BIT_KEY_WRITE_ENABLE - 5];
			key_wr_q <= key_wr_d;
			key_idx_q <= key_idx_d;
			key_data_q <= key_data_d;
			array_start_q <= start_d;
			array_cmd_q <= a_cmd_d;
			array_addr_q <= a_addr_d;
			array_data_q <= a_data_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_cfg_low_zero: assert property (setup && paddr == `FCS_OFS_CONFIG |=>
		prdata_q[4:0] == 5'h00) else $error("config low bits not zero");
	a_status_zero: assert property (setup && paddr == `FCS_OFS_STATUS |=>
		!prdata_q[3] && !prdata_q[1] && !prdata_q[0]) else $error("status zero bits set");
	a_prot_user_ro: assert property (prot_ld_q && !bdm_prot_wr |=>
		$stable(prot_q)) else $error("protection changed without debug write");
	a_launch_clears: assert property (launch_ok && !busy_q |=>
		!cbef_q && !ccf_q ##1 array_start_q) else $error("launch not taken");
	a_pviol_set: assert property (launch && seq_q == fcs_pkg::FCS_SEQ_CMD && legal &&
		divisor_loaded_q && prot_hit |=> pviol_q && cbef_q == $past(cbef_q))
		else $error("protection violation missed");
	a_illegal_err: assert property (launch && !legal |=> accerr_q)
		else $error("illegal code without access error");
	a_accerr_hold: assert property (accerr_q && !(wr_stat && pwdata[`FCS_BIT_ACCERR]) |=>
		accerr_q) else $error("access error lost");
	a_no_div_start: assert property (!divisor_loaded_q |-> !launch_ok)
		else $error("command launched before divider write");
	a_blank_unsec: assert property (busy_q && array_done && run_cmd_q == `FCS_CMD_BLANK &&
		array_blank_ok && !stop_req |=> blank_q && security_state_code_q == `FCS_SEC_UNSEC)
		else $error("blank check result not recorded");
	c_burst_overlap: cover property (launch_ok && busy_q);
	c_blank_pass: cover property (array_done && run_cmd_q == `FCS_CMD_BLANK && array_blank_ok);
	c_pviol: cover property (!pviol_q ##1 pviol_q);
	c_stop_abort: cover property (stop_req && busy_q);
endmodule // fcs_ctrl

// ---- hw/fcs_defines.svh ----
// Purpose: offsets, field positions, codes and reset values of the flash control block
// Assumes: byte addresses on a 32-bit APB, one register per aligned word
// Notes: definitions only
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
// ****************************************
// register offsets
// ****************************************
`define FCS_OFS_CONFIG 8'h00
`define FCS_OFS_PROT 8'h04
`define FCS_OFS_STATUS 8'h08
`define FCS_OFS_CMD 8'h0c
`define FCS_OFS_DIV 8'h10
`define FCS_OFS_SEC 8'h14
// ****************************************
// field positions and masks
// ****************************************
`define FCS_BIT_KEY_WRITE_ENABLE 5
`define FCS_BIT_PDIS 0
`define FCS_BIT_CBEF 7
`define FCS_BIT_CCF 6
`define FCS_BIT_PVIOL 5
`define FCS_BIT_ACCERR 4
`define FCS_BIT_BLANK 2
`define FCS_BIT_DIVISOR_LOADED 7
`define FCS_CFG_MASK 8'he0
// ****************************************
// command codes and values
// ****************************************
`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_BYTE 8'h20
`define FCS_CMD_BURST 8'h25
`define FCS_CMD_PAGE 8'h40
`define FCS_CMD_MASS 8'h41
`define FCS_KEY_LO 16'hffb0
`define FCS_KEY_HI 16'hffb7
`define FCS_UNPROT_LOW 9'h1ff
`define FCS_ERASED 8'hff
`define FCS_SEC_UNSEC 2'h2
`define FCS_SEC_RST 2'h0
`define FCS_PROT_RST 8'h01
`endif

// ---- hw/fcs_pkg.sv ----
// Purpose: types shared by the flash control block
// Assumes: nothing
// Notes: command sequence states are gray coded along idle, data, command
package fcs_pkg;
	typedef enum logic [1:0] {
		FCS_SEQ_IDLE = 2'h0,
		FCS_SEQ_DATA = 2'h1,
		FCS_SEQ_CMD = 2'h3
	} fcs_seq_t;
endpackage

// ---- hw/fcs_apb_slave.sv ----
// Purpose: apb handshake and address decode for the flash control registers
// Assumes: apb3 master, no wait beyond one access cycle
// Notes: pready is a flop, high in the first access cycle
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_apb_slave (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	// decode
	output logic pready_q,
	output logic setup,
	output logic done,
	output logic mapped
);
	logic pready_d;

	assign setup = psel & ~penable;
	assign done = psel & penable & pready_q;
	assign mapped = (paddr == `FCS_OFS_CONFIG) | (paddr == `FCS_OFS_PROT) |
		(paddr == `FCS_OFS_STATUS) | (paddr == `FCS_OFS_CMD) |
		(paddr == `FCS_OFS_DIV) | (paddr == `FCS_OFS_SEC);

	always_comb
	begin
		pready_d = setup;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_q <= 1'b0;
		else
			pready_q <= pready_d;
	end
endmodule // fcs_apb_slave

// ---- hw/fcs_prot_chk.sv ----
// Purpose: decides whether a command would touch a protected flash location
// Assumes: 16-bit flash addresses, protected region at the high end
// Notes: purely combinational
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_prot_chk (
	// inputs
	input wire logic [7:0] prot,
	input wire logic [7:0] cmd,
	input wire logic [15:0] addr,
	// result
	output logic hit
);
	logic above;

	always_comb
	begin
		above = addr > {prot[7:1], `FCS_UNPROT_LOW};
		hit = 1'b0;
		if (!prot[`FCS_BIT_PDIS])
		begin
			case (cmd)
				`FCS_CMD_MASS: hit = 1'b1;
				`FCS_CMD_BYTE, `FCS_CMD_BURST, `FCS_CMD_PAGE: hit = above;
				default: hit = 1'b0;
			endcase
		end
	end
endmodule // fcs_prot_chk

// ---- sim/fcs_eng_model.sv ----
// Purpose: behavioural flash array engine on the far side of the control block
// Assumes: one command in the engine at a time, start is a one-cycle pulse
// Notes: the blank result only means something with done, so it toggles otherwise
`timescale 1ns/1ps
module fcs_eng_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench control
	input wire logic slow,
	input wire logic blank_ok_in,
	// engine side
	input wire logic array_start_q,
	output logic array_done,
	output logic array_blank_ok
);
	logic [5:0] cnt_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 6'h00;
			array_done <= 1'b0;
			array_blank_ok <= 1'b0;
		end
		else
		begin
			array_done <= (cnt_q == 6'h01);
			array_blank_ok <= (cnt_q == 6'h01) ? blank_ok_in : ~array_blank_ok;
			// slow run lets a burst wait in the buffer
			if (array_start_q)
				cnt_q <= slow ? 6'h1e : 6'h02;
			else if (cnt_q != 6'h00)
				cnt_q <= cnt_q - 6'h01;
		end
	end
endmodule // fcs_eng_model

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the flash command and status control
// Assumes: wait-free apb slave, array engine model on the far side
// Notes: random data from a fixed seed, corner cases written by hand
`timescale 1ns/1ps
module tb;
	logic pclk, presetn, psel, penable, pwrite, flash_wr, bdm_prot_wr, stop_req, slow;
	logic blank_ok_in, pready_q, pslverr_q, read_invalid_q, key_wr_q, array_start_q;
	logic array_done, array_blank_ok, serr;
	logic [7:0] paddr, flash_wr_data, nonvolatile_protection_byte, bdm_prot_data, rd, d, ill;
	logic [7:0] key_data_q, array_cmd_q, array_data_q;
	logic [31:0] pwdata, prdata_q;
	logic [15:0] flash_wr_addr, array_addr_q;
	logic [2:0] key_idx_q;
	logic [1:0] security_state_code_q;
	logic [10:0] kcap;
	logic [7:0] codes [6];
	int error_cnt = 0;
	int checks = 0;
	int starts = 0;
	int s0;
	fcs_ctrl dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata_q(prdata_q),
		.pready_q(pready_q),
		.pslverr_q(pslverr_q),
		.flash_wr(flash_wr),
		.flash_wr_addr(flash_wr_addr),
		.flash_wr_data(flash_wr_data),
		.read_invalid_q(read_invalid_q),
		.key_wr_q(key_wr_q),
		.key_idx_q(key_idx_q),
		.key_data_q(key_data_q),
		.nonvolatile_protection_byte(nonvolatile_protection_byte),
		.bdm_prot_wr(bdm_prot_wr),
		.bdm_prot_data(bdm_prot_data),
		.stop_req(stop_req),
		.array_start_q(array_start_q),
		.array_cmd_q(array_cmd_q),
		.array_addr_q(array_addr_q),
		.array_data_q(array_data_q),
		.array_done(array_done),
		.array_blank_ok(array_blank_ok),
		.security_state_code_q(security_state_code_q)
	);
	fcs_eng_model eng (
		.pclk(pclk),
		.presetn(presetn),
		.slow(slow),
		.blank_ok_in(blank_ok_in),
		.array_start_q(array_start_q),
		.array_done(array_done),
		.array_blank_ok(array_blank_ok)
	);
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		if (array_start_q === 1'b1)
			starts <= starts + 1;
		if (key_wr_q === 1'b1)
			kcap <= {key_idx_q, key_data_q};
	end
	// ****************************
	// bus tasks and expectations
	// ****************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do
		begin
			@(posedge pclk);
		end
		while (pready_q !== 1'b1);
		rd = prdata_q[7:0];
		serr = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		apb(1'b0, a, 8'h00);
		chk("register", e, rd & m);
	endtask
	task automatic fw(input logic [15:0] a, input logic [7:0] wd);
		@(posedge pclk);
		flash_wr <= 1'b1;
		flash_wr_addr <= a;
		flash_wr_data <= wd;
		@(posedge pclk);
		flash_wr <= 1'b0;
	endtask
	task automatic bdm(input logic [7:0] v);
		@(posedge pclk);
		bdm_prot_wr <= 1'b1;
		bdm_prot_data <= v;
		@(posedge pclk);
		bdm_prot_wr <= 1'b0;
	endtask
	task automatic launch(input logic [15:0] a, input logic [7:0] c);
		fw(a, 8'($urandom));
		apb(1'b1, 8'h0c, c);
		apb(1'b1, 8'h08, 8'h80);
	endtask
	task automatic wait_ccf();
		rd = 8'h00;
		for (int i = 0; i < 100 && rd[6] !== 1'b1; i++)
			apb(1'b0, 8'h08, 8'h00);
	endtask
	function automatic logic legal(input logic [7:0] c);
		return c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
	endfunction
	function automatic logic [7:0] exp_stat(input logic [7:0] c);
		if (!legal(c))
			return 8'hd0;
		return (c == 8'h05) ? 8'hc4 : 8'hc0;
	endfunction
	task automatic wrap_up();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		wrap_up();
	end
	// ****************************
	// main sequence
	// ****************************
	initial
	begin
		{presetn, psel, penable, pwrite, flash_wr, bdm_prot_wr, stop_req, slow} = 8'h00;
		{paddr, flash_wr_data, bdm_prot_data, flash_wr_addr, pwdata} = 72'h0;
		blank_ok_in = 1'b1;
		void'($urandom(82867));
		nonvolatile_protection_byte = 8'($urandom);
		ill = 8'($urandom);
		while (legal(ill))
			ill = ill + 8'h01;
		codes = '{ill, 8'h20, 8'h25, 8'h40, 8'h41, 8'h05};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdc(8'h04, nonvolatile_protection_byte, 8'hff);
		rdc(8'h08, 8'hc0, 8'hff);
		rdc(8'h10, 8'h00, 8'h80);
		rdc(8'h14, 8'h00, 8'h03);
		apb(1'b0, 8'h18, 8'h00);
		chk("unmapped", 1'b1, serr);
		apb(1'b1, 8'h08, 8'h4f);
		rdc(8'h08, 8'hc0, 8'hff);
		bdm(8'h01);
		launch(16'h0100, 8'h20);
		rdc(8'h08, 8'hd0, 8'hff);
		apb(1'b1, 8'h08, 8'h00);
		rdc(8'h08, 8'hd0, 8'hff);
		apb(1'b1, 8'h08, 8'h10);
		rdc(8'h08, 8'hc0, 8'hff);
		d = 8'($urandom);
		apb(1'b1, 8'h10, d);
		rdc(8'h10, {1'b1, d[6:0]}, 8'hff);
		d = 8'($urandom);
		apb(1'b1, 8'h00, d);
		rdc(8'h00, d & 8'he0, 8'hff);
		apb(1'b1, 8'h00, 8'h20);
		// the flag lands at the write edge, look one edge later
		@(posedge pclk);
		chk("read_invalid", 1'b1, read_invalid_q);
		d = 8'($urandom);
		fw(16'hffb5, d);
		repeat (2) @(posedge pclk);
		chk("key", {3'h5, d}, kcap);
		apb(1'b1, 8'h00, 8'h00);
		apb(1'b1, 8'h04, 8'hfe);
		rdc(8'h04, 8'h01, 8'hff);
		for (int i = 0; i < 6; i++)
		begin
			s0 = starts;
			launch(16'hffb2, codes[i]);
			wait_ccf();
			rdc(8'h08, exp_stat(codes[i]), 8'hff);
			chk("starts", s0 + legal(codes[i]), starts);
			if (legal(codes[i]))
				chk("array_cmd", codes[i], array_cmd_q);
			if (legal(codes[i]))
				chk("array_addr", 16'hffb2, array_addr_q);
			apb(1'b1, 8'h08, 8'h10);
		end
		rdc(8'h14, 8'h02, 8'h03);
		slow <= 1'b1;
		s0 = starts;
		launch(16'h0200, 8'h25);
		// buffer-empty comes back one edge after the launch
		repeat (3) @(posedge pclk);
		launch(16'h0201, 8'h25);
		rdc(8'h08, 8'h00, 8'hd0);
		wait_ccf();
		rdc(8'h08, 8'hc0, 8'hff);
		chk("starts", s0 + 2, starts);
		bdm(8'h00);
		rdc(8'h04, 8'h00, 8'hff);
		s0 = starts;
		launch(16'hfff0, 8'h20);
		wait_ccf();
		rdc(8'h08, 8'he0, 8'hff);
		apb(1'b1, 8'h08, 8'h20);
		rdc(8'h08, 8'hc0, 8'hff);
		launch({7'h00, 9'($urandom)}, 8'h20);
		wait_ccf();
		chk("starts", s0 + 1, starts);
		bdm(8'h01);
		launch(16'h0300, 8'h40);
		repeat (4) @(posedge pclk);
		stop_req <= 1'b1;
		@(posedge pclk);
		stop_req <= 1'b0;
		repeat (40) @(posedge pclk);
		rdc(8'h08, 8'h10, 8'h10);
		wrap_up();
	end
endmodule // tb
